/* File: design/bridge_seq_pkg.sv */
// Constants and types shared by the phase-shift bridge sequencer
package bridge_seq_pkg;

	// System clock period in picoseconds (200 MHz)
	localparam int unsigned CLOCK_PERIOD_PS = 5000;

	// Default zero-voltage override delay, printed figure in ns
	localparam int unsigned DEFAULT_DELAY_NS = 320;

	// Longest wait, so round down; never below one cycle
	localparam int unsigned DEFAULT_DELAY_RAW = (DEFAULT_DELAY_NS * 1000) / CLOCK_PERIOD_PS;
	localparam int unsigned DEFAULT_DELAY_CYC = (DEFAULT_DELAY_RAW < 1) ? 1 : DEFAULT_DELAY_RAW;

	// Width of the override delay counter
	localparam int unsigned DELAY_CNT_W = 8;

	// Number of pin inputs passed through the synchroniser
	localparam int unsigned PIN_COUNT = 5;

	// Bit positions inside the synchronised pin vector
	localparam int unsigned PIN_OSC = 0;
	localparam int unsigned PIN_TRIP = 1;
	localparam int unsigned PIN_PASSIVE_ZV = 2;
	localparam int unsigned PIN_ACTIVE_ZV = 3;
	localparam int unsigned PIN_ENABLE = 4;

	// Reset values of the synchroniser and the diagonal phase
	localparam logic [PIN_COUNT-1:0] PINS_RESET = 5'h00;
	localparam logic PHASE_RESET = 1'b0;

	// Sequencer states: off, two power pulses, two freewheel intervals
	typedef enum logic [2:0] {
		st_off,
		st_power_one,
		st_free_one,
		st_power_two,
		st_free_two
	} seq_state_t;

endpackage : bridge_seq_pkg

/* File: design/pin_sync.sv */
// Two-flop synchroniser for the asynchronous pin inputs
`timescale 1ns/1ps
module pin_sync (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic [bridge_seq_pkg::PIN_COUNT-1:0] pins_i,
	output logic [bridge_seq_pkg::PIN_COUNT-1:0] pins_o
);
	import bridge_seq_pkg::*;

	logic [PIN_COUNT-1:0] meta;

	// First stage feeds only the second stage
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			meta <= PINS_RESET;
			pins_o <= PINS_RESET;
		end else begin
			meta <= pins_i;
			pins_o <= meta;
		end
	end

endmodule : pin_sync

/* File: design/zvs_gate.sv */
// Turn-on gate for one bridge switch: waits for zero voltage or timeout
`timescale 1ns/1ps
module zvs_gate (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic command_i,
	input wire logic partner_off_i,
	input wire logic zv_ready_i,
	output logic drive_o
);
	import bridge_seq_pkg::*;

	logic [DELAY_CNT_W-1:0] wait_count;
	wire armed;
	wire timed_out;
	wire next_drive;

	// Armed once commanded and the opposite switch of the leg is off
	assign armed = command_i && partner_off_i && !drive_o;
	assign timed_out = (wait_count >= DELAY_CNT_W'(DEFAULT_DELAY_CYC));
	// Turn-off is immediate; turn-on waits for sensing or the override
	assign next_drive = command_i && (drive_o || (armed && (zv_ready_i || timed_out)));

	// Counter restarts whenever arming drops, so a stale wait never carries
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			wait_count <= '0;
			drive_o <= 1'b0;
		end else begin
			wait_count <= armed ? (timed_out ? wait_count : wait_count + 1'b1) : '0;
			drive_o <= next_drive;
		end
	end

	// Override fires at the programmed delay
	property p_default_timeout;
		@(posedge clock_i) disable iff (sys_rst_i)
		(armed && command_i && timed_out) |=> drive_o;
	endproperty
	a_default_timeout: assert property (p_default_timeout) else $error("override did not fire");

	// Turn-on only after partner off and sensing or timeout
	property p_wait_turn_on;
		@(posedge clock_i) disable iff (sys_rst_i)
		$rose(drive_o) |-> $past(partner_off_i) && ($past(zv_ready_i) || $past(timed_out));
	endproperty
	a_wait_turn_on: assert property (p_wait_turn_on) else $error("turn-on without zv or timeout");

endmodule : zvs_gate

/* File: design/phase_shift_bridge_sequencer.sv */
// Phase-shifted full-bridge sequencer: state machine, drives, checks
`timescale 1ns/1ps
module phase_shift_bridge_sequencer (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic osc_clock_i,
	input wire logic modulator_trip_i,
	input wire logic passive_zv_ready_i,
	input wire logic active_zv_ready_i,
	input wire logic run_enable_i,
	output logic passive_high_drive_o,
	output logic passive_low_drive_o,
	output logic active_high_drive_o,
	output logic active_low_drive_o,
	output logic rectifier_one_drive_o,
	output logic rectifier_two_drive_o,
	output logic diagonal_phase_o
);
	import bridge_seq_pkg::*;

	logic [PIN_COUNT-1:0] pins_sync;
	logic osc_prev;
	logic trip_prev;
	logic tick_pending;
	seq_state_t state;
	seq_state_t next_state;
	logic next_phase;
	logic next_pending;

	wire osc_tick;
	wire trip_evt;
	wire run_ok;
	wire passive_high_cmd;
	wire passive_low_cmd;
	wire active_high_cmd;
	wire active_low_cmd;
	wire next_rect_one;
	wire next_rect_two;

	// Pins enter through two flops before anything looks at them
	pin_sync u_pin_sync (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.pins_i({run_enable_i, active_zv_ready_i, passive_zv_ready_i,
			modulator_trip_i, osc_clock_i}),
		.pins_o(pins_sync)
	);

	// Rising edges of the oscillator pulse and the comparator trip
	assign osc_tick = pins_sync[PIN_OSC] && !osc_prev;
	assign trip_evt = pins_sync[PIN_TRIP] && !trip_prev;
	assign run_ok = pins_sync[PIN_ENABLE];

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			osc_prev <= 1'b0;
			trip_prev <= 1'b0;
		end else begin
			osc_prev <= pins_sync[PIN_OSC];
			trip_prev <= pins_sync[PIN_TRIP];
		end
	end

	// Four-state cycle; a tick with no trip ends the pulse at full duty
	always_comb begin
		next_state = state;
		next_phase = diagonal_phase_o;
		next_pending = 1'b0;
		case (state)
			st_off: begin
				if (run_ok) begin
					next_state = st_power_one;
					next_phase = PHASE_RESET;
				end
			end
			st_power_one: begin
				if (trip_evt || osc_tick) begin
					next_state = st_free_one;
					next_pending = osc_tick;
				end
			end
			st_free_one: begin
				if (osc_tick || tick_pending) begin
					next_state = st_power_two;
					next_phase = !diagonal_phase_o;
				end
			end
			st_power_two: begin
				if (trip_evt || osc_tick) begin
					next_state = st_free_two;
					next_pending = osc_tick;
				end
			end
			st_free_two: begin
				if (osc_tick || tick_pending) begin
					next_state = st_power_one;
					next_phase = !diagonal_phase_o;
				end
			end
			default: begin
				next_state = st_off;
			end
		endcase
		if (!run_ok) begin
			next_state = st_off;
			next_phase = PHASE_RESET;
		end
	end

	// Left leg follows the oscillator phase only, so it is the passive leg
	assign passive_high_cmd = (state == st_power_one) || (state == st_free_one);
	assign passive_low_cmd = (state == st_power_two) || (state == st_free_two);
	// Right leg flips on the comparator trip, shifting it against the left
	assign active_low_cmd = (state == st_power_one) || (state == st_free_two);
	assign active_high_cmd = (state == st_free_one) || (state == st_power_two);

	// Rectifier two pairs with passive high/active low, one with the others
	assign next_rect_one = (next_state == st_free_one) || (next_state == st_power_two)
		|| (next_state == st_free_two);
	assign next_rect_two = (next_state == st_power_one) || (next_state == st_free_one)
		|| (next_state == st_free_two);

	// State, phase and rectifier drives
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			state <= st_off;
			diagonal_phase_o <= PHASE_RESET;
			tick_pending <= 1'b0;
			rectifier_one_drive_o <= 1'b0;
			rectifier_two_drive_o <= 1'b0;
		end else begin
			state <= next_state;
			diagonal_phase_o <= next_phase;
			tick_pending <= next_pending;
			rectifier_one_drive_o <= next_rect_one;
			rectifier_two_drive_o <= next_rect_two;
		end
	end

	// One gate per bridge switch; dead time keeps each high time under half
	zvs_gate u_passive_high (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.command_i(passive_high_cmd),
		.partner_off_i(!passive_low_drive_o),
		.zv_ready_i(pins_sync[PIN_PASSIVE_ZV]),
		.drive_o(passive_high_drive_o)
	);

	zvs_gate u_passive_low (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.command_i(passive_low_cmd),
		.partner_off_i(!passive_high_drive_o),
		.zv_ready_i(pins_sync[PIN_PASSIVE_ZV]),
		.drive_o(passive_low_drive_o)
	);

	zvs_gate u_active_high (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.command_i(active_high_cmd),
		.partner_off_i(!active_low_drive_o),
		.zv_ready_i(pins_sync[PIN_ACTIVE_ZV]),
		.drive_o(active_high_drive_o)
	);

	zvs_gate u_active_low (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.command_i(active_low_cmd),
		.partner_off_i(!active_high_drive_o),
		.zv_ready_i(pins_sync[PIN_ACTIVE_ZV]),
		.drive_o(active_low_drive_o)
	);

	// Phase flips on every tick in a freewheel state while running
	property p_phase_toggle;
		@(posedge clock_i) disable iff (sys_rst_i)
		((state == st_free_one || state == st_free_two) && osc_tick && run_ok)
			|=> diagonal_phase_o != $past(diagonal_phase_o);
	endproperty
	a_phase_toggle: assert property (p_phase_toggle) else $error("phase did not toggle");

	// Passive high only starts in the first diagonal phase
	property p_half_rate;
		@(posedge clock_i) disable iff (sys_rst_i)
		$rose(passive_high_drive_o) |-> $past(diagonal_phase_o) == 1'b0;
	endproperty
	a_half_rate: assert property (p_half_rate) else $error("passive high in wrong phase");

	// Passive low only starts in the second diagonal phase
	property p_half_rate_low;
		@(posedge clock_i) disable iff (sys_rst_i)
		$rose(passive_low_drive_o) |-> $past(diagonal_phase_o) == 1'b1;
	endproperty
	a_half_rate_low: assert property (p_half_rate_low) else $error("low in wrong phase");

	// Never both switches of a leg on
	property p_no_overlap;
		@(posedge clock_i) disable iff (sys_rst_i)
		!(passive_high_drive_o && passive_low_drive_o)
			&& !(active_high_drive_o && active_low_drive_o);
	endproperty
	a_no_overlap: assert property (p_no_overlap) else $error("leg shoot-through");

	// Trip moves active leg while passive leg holds
	property p_trip_moves_active;
		@(posedge clock_i) disable iff (sys_rst_i)
		(state == st_power_one && trip_evt && run_ok)
			|=> state == st_free_one ##1 !active_low_drive_o && passive_high_cmd;
	endproperty
	a_trip_moves_active: assert property (p_trip_moves_active) else $error("trip ignored");

	// Active high only while the active leg is flipped
	property p_active_leg;
		@(posedge clock_i) disable iff (sys_rst_i)
		$rose(active_high_drive_o) |-> ($past(state) == st_free_one || $past(state) == st_power_two);
	endproperty
	a_active_leg: assert property (p_active_leg) else $error("active high out of turn");

	// Power one must pass through a freewheel before power two
	property p_four_states;
		@(posedge clock_i) disable iff (sys_rst_i)
		state == st_power_one |=> state != st_power_two && state != st_free_two;
	endproperty
	a_four_states: assert property (p_four_states) else $error("state skipped");

	// Outputs in the first power state
	property p_power_one_outputs;
		@(posedge clock_i) disable iff (sys_rst_i)
		(state == st_power_one) |-> rectifier_two_drive_o && !rectifier_one_drive_o
			&& !active_high_drive_o && passive_high_cmd && active_low_cmd;
	endproperty
	a_power_one_outputs: assert property (p_power_one_outputs) else $error("state 1 outputs");

	// End of state one: rectifier one on, active low off a cycle later
	property p_end_state_one;
		@(posedge clock_i) disable iff (sys_rst_i)
		(state == st_power_one && trip_evt && run_ok)
			|=> rectifier_one_drive_o ##1 !active_low_drive_o;
	endproperty
	a_end_state_one: assert property (p_end_state_one) else $error("state 1 end");

	// Both rectifiers conduct through the first freewheel
	property p_free_one_rects;
		@(posedge clock_i) disable iff (sys_rst_i)
		(state == st_free_one) |-> rectifier_one_drive_o && rectifier_two_drive_o;
	endproperty
	a_free_one_rects: assert property (p_free_one_rects) else $error("state 2 rectifiers");

	// End of state two on the clock tick
	property p_end_state_two;
		@(posedge clock_i) disable iff (sys_rst_i)
		(state == st_free_one && osc_tick && run_ok)
			|=> !rectifier_two_drive_o ##1 !passive_high_drive_o;
	endproperty
	a_end_state_two: assert property (p_end_state_two) else $error("state 2 end");

	// Passive high never drops except on the tick or disable
	property p_passive_off_tick;
		@(posedge clock_i) disable iff (sys_rst_i)
		$fell(passive_high_drive_o) |-> $past(osc_tick, 2) || $past(tick_pending, 2)
			|| $past(osc_tick, 3) || !$past(run_ok, 2);
	endproperty
	a_passive_off_tick: assert property (p_passive_off_tick) else $error("early passive off");

	// Rectifier one on and rectifier two off during second power state
	property p_rect_pairing;
		@(posedge clock_i) disable iff (sys_rst_i)
		(state == st_power_two) |-> rectifier_one_drive_o && !rectifier_two_drive_o;
	endproperty
	a_rect_pairing: assert property (p_rect_pairing) else $error("rectifier pairing");

	// Main scenarios
	c_full_cycle: cover property (@(posedge clock_i) disable iff (sys_rst_i)
		state == st_free_two ##1 state == st_power_one);
	c_trip_end: cover property (@(posedge clock_i) disable iff (sys_rst_i)
		state == st_power_one && trip_evt);
	c_full_duty: cover property (@(posedge clock_i) disable iff (sys_rst_i)
		state == st_power_two && osc_tick);
	c_pending_tick: cover property (@(posedge clock_i) disable iff (sys_rst_i)
		state == st_free_two && tick_pending);
	c_drop_enable: cover property (@(posedge clock_i) disable iff (sys_rst_i)
		state != st_off && !run_ok);

endmodule : phase_shift_bridge_sequencer

/* File: tb/bridge_leg_model.sv */
// Behavioural bridge legs with gate drivers, answering with zero-voltage ready
`timescale 1ns/1ps
module bridge_leg_model #(
	parameter int ZV_DELAY = 6
) (
	input wire logic clock_i,
	input wire logic slow_i,
	input wire logic passive_high_i,
	input wire logic passive_low_i,
	input wire logic active_high_i,
	input wire logic active_low_i,
	output logic passive_zv_ready_o,
	output logic active_zv_ready_o,
	output logic shoot_through_o
);
	int passive_idle = 0;
	int active_idle = 0;
	// A leg swings only while both its switches are off
	always @(posedge clock_i) begin
		passive_idle <= (passive_high_i || passive_low_i) ? 0 : passive_idle + 1;
		active_idle <= (active_high_i || active_low_i) ? 0 : active_idle + 1;
	end
	// Slow mode: too little energy, the leg never reaches zero voltage
	assign passive_zv_ready_o = !slow_i && (passive_idle >= ZV_DELAY);
	assign active_zv_ready_o = !slow_i && (active_idle >= ZV_DELAY);
	// Sticky flag: both switches of one leg on would short the supply
	initial shoot_through_o = 1'b0;
	always @(posedge clock_i) begin
		if ((passive_high_i && passive_low_i) || (active_high_i && active_low_i)) begin
			shoot_through_o <= 1'b1;
		end
	end
endmodule : bridge_leg_model

/* File: tb/tb.sv */
// Self-checking bench for the phase-shift bridge sequencer
`timescale 1ns/1ps
module tb;
	import bridge_seq_pkg::*;
	localparam int P = 60;
	logic clock_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic osc_clock_i = 1'b0;
	logic modulator_trip_i = 1'b0;
	logic run_enable_i = 1'b0;
	logic slow = 1'b0;
	logic passive_zv, active_zv, shoot_through;
	logic ph, pl, ah, al, r1, r2, phase;
	logic ph_q = 1'b0;
	logic measure = 1'b0;
	int failures = 0;
	int check_count = 0;
	int overlap = 0;
	int high_cnt = 0;
	int rises = 0;
	wire logic [6:0] outs = {phase, ph, pl, ah, al, r1, r2};

	// 200 MHz clock
	always #2.5 clock_i = ~clock_i;

	phase_shift_bridge_sequencer u_phase_shift_bridge_sequencer (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.osc_clock_i(osc_clock_i),
		.modulator_trip_i(modulator_trip_i),
		.passive_zv_ready_i(passive_zv),
		.active_zv_ready_i(active_zv),
		.run_enable_i(run_enable_i),
		.passive_high_drive_o(ph),
		.passive_low_drive_o(pl),
		.active_high_drive_o(ah),
		.active_low_drive_o(al),
		.rectifier_one_drive_o(r1),
		.rectifier_two_drive_o(r2),
		.diagonal_phase_o(phase)
	);

	bridge_leg_model u_bridge_leg_model (
		.clock_i(clock_i),
		.slow_i(slow),
		.passive_high_i(ph),
		.passive_low_i(pl),
		.active_high_i(ah),
		.active_low_i(al),
		.passive_zv_ready_o(passive_zv),
		.active_zv_ready_o(active_zv),
		.shoot_through_o(shoot_through)
	);

	// Diagonal overlap, high time and turn-ons of the passive high drive
	always @(posedge clock_i) begin
		if (measure) begin
			if (ph && al) overlap++;
			if (ph) high_cnt++;
			if (ph && !ph_q) rises++;
		end
		ph_q <= ph;
	end

	task automatic wait_cyc(input int n);
		repeat (n) @(negedge clock_i);
	endtask : wait_cyc

	task automatic check_vec(input logic [6:0] got, input logic [6:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_vec

	task automatic check_num(input int got, input int exp);
		check_count++;
		if (got != exp) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_num

	// Pin pulses two cycles wide, well inside the synchroniser's reach
	task automatic pulse_osc;
		osc_clock_i = 1'b1;
		wait_cyc(2);
		osc_clock_i = 1'b0;
	endtask : pulse_osc

	task automatic pulse_trip;
		modulator_trip_i = 1'b1;
		wait_cyc(2);
		modulator_trip_i = 1'b0;
	endtask : pulse_trip

	task automatic run_periods(input int trip_at);
		for (int i = 0; i < 4; i++) begin
			pulse_osc();
			wait_cyc(trip_at - 2);
			pulse_trip();
			wait_cyc(P - trip_at - 2);
		end
	endtask : run_periods

	// Enable, then walk one full transformer cycle state by state
	task automatic t_walk;
		run_enable_i = 1'b1;
		wait_cyc(30);
		check_vec(outs, 7'h25);
		pulse_trip();
		wait_cyc(5);
		check_vec(outs, 7'h23);
		wait_cyc(13);
		check_vec(outs, 7'h2b);
		pulse_osc();
		wait_cyc(5);
		check_vec(outs, 7'h4a);
		wait_cyc(13);
		check_vec(outs, 7'h5a);
		pulse_trip();
		wait_cyc(5);
		check_vec(outs, 7'h53);
		wait_cyc(13);
		check_vec(outs, 7'h57);
	endtask : t_walk

	// Later trip must lengthen the diagonal overlap by exactly twice the shift over the four periods
	task automatic t_duty;
		int base;
		overlap = 0;
		high_cnt = 0;
		rises = 0;
		measure = 1'b1;
		run_periods(20);
		measure = 1'b0;
		base = overlap;
		check_num(rises, 2);
		check_num(int'(high_cnt < 2 * P), 1);
		overlap = 0;
		measure = 1'b1;
		run_periods(30);
		measure = 1'b0;
		check_num(overlap - base, 20);
	endtask : t_duty

	// Leg never settles: turn-on must come from the default delay
	task automatic t_slow;
		slow = 1'b1;
		pulse_osc();
		wait_cyc(48);
		check_vec(outs, 7'h05);
		wait_cyc(30);
		check_vec(outs, 7'h25);
		pulse_trip();
		slow = 1'b0;
		wait_cyc(20);
	endtask : t_slow

	// No trip in a power state: the tick ends it at full duty
	task automatic t_full_duty;
		pulse_osc();
		wait_cyc(5);
		check_vec(outs, 7'h4a);
		wait_cyc(P - 7);
		pulse_osc();
		wait_cyc(5);
		check_vec(outs, 7'h01);
		wait_cyc(13);
		check_vec(outs, 7'h25);
	endtask : t_full_duty

	// Dropping the enable turns every drive off
	task automatic t_disable;
		run_enable_i = 1'b0;
		wait_cyc(8);
		check_vec(outs, 7'h00);
		check_vec({6'h00, shoot_through}, 7'h00);
	endtask : t_disable

	task automatic end_sim;
		if (failures == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_sim

	// Main sequence
	initial begin
		wait_cyc(3);
		sys_rst_i = 1'b0;
		check_vec(outs, 7'h00);
		t_walk();
		t_duty();
		t_slow();
		t_full_duty();
		t_disable();
		end_sim();
	end

	// Watchdog, about thirteen times the expected run
	initial begin
		#50000;
		failures++;
		end_sim();
	end
endmodule : tb
